// ### hdl/misc_regs_pkg.sv
// How it works
// - Bits 14-13 aux/touch pins drive code
// - Bit 12 display pins drive strength
// - Bits 11-10 host/flash serial drive code
// - Bit 9 selects interrupt pin type
// - Bit 15 display enable pin level, bits 3-0 aux pin levels; others reserved
// - Frequency register read-write, resets to default
// - Cycle counter counts clocks, wraps, read-only
// - Frame counter counts frames, wraps, read-only
// - Direction bit one means output pin
package misc_regs_pkg;
	localparam logic [11:0] frame_count_off       = 12'h004;
	localparam logic [11:0] clock_cycle_count_off = 12'h008;
	localparam logic [11:0] main_clock_hertz_off  = 12'h00C;
	localparam logic [11:0] pin_direction_off     = 12'h098;
	localparam logic [11:0] pin_level_drive_off   = 12'h09C;
	localparam logic [31:0] main_clock_hertz_rst  = 32'h03938700;
	localparam logic [31:0] pin_level_drive_rst   = 32'h00008000;
	localparam logic [31:0] pin_level_drive_mask  = 32'h0000FE0F;
	localparam logic [31:0] pin_direction_rst     = 32'h00008000;
	localparam logic [31:0] pin_direction_mask    = 32'h0000800F;
	localparam int          display_enable_pin_bit              = 15;
	localparam int          aux_drive_lo          = 13;
	localparam int          video_drive_bit       = 12;
	localparam int          serial_drive_lo       = 10;
	localparam int          irq_type_bit          = 9;
endpackage : misc_regs_pkg

// ### hdl/misc_gpio_and_counters.sv
`timescale 1ns/10ps
module misc_gpio_and_counters (
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Frame event
	input  wire logic        frame_done_i,
	// Pins, output enable low while driving
	input  wire logic        display_enable_pin_i,
	output logic             display_enable_pin_o,
	output logic             display_enable_pin_oe_n_o,
	input  wire logic [3:0]  aux_pin_i,
	output logic      [3:0]  aux_pin_o,
	output logic      [3:0]  aux_pin_oe_n_o,
	// Pad settings
	output logic      [1:0]  aux_drive_o,
	output logic             video_drive_o,
	output logic      [1:0]  serial_drive_o,
	output logic             irq_push_pull_o
);
	import misc_regs_pkg::*;

	// Reset release
	logic        rst_meta_r;
	logic        rst_sync_r;
	// Bus decode
	logic        wr_en;
	logic        rd_en;
	logic        hit;
	logic        wr_ctl;
	logic        wr_dir;
	logic        wr_hertz;
	logic        wr_frames;
	logic        wr_cycles;
	// Register state
	logic [31:0] pin_ctl_r;
	logic [31:0] pin_ctl_nxt;
	logic [31:0] pin_dir_r;
	logic [31:0] pin_dir_nxt;
	logic [31:0] hertz_r;
	logic [31:0] hertz_nxt;
	logic [31:0] cycles_r;
	logic [31:0] cycles_nxt;
	logic [31:0] frames_r;
	logic [31:0] frames_nxt;
	logic [31:0] rdata_nxt;

	// Address match, used by every write strobe
	function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] off);
		addr_is = (addr == off);
	endfunction : addr_is

	// Wrapping increment shared by both counters
	function automatic logic [31:0] step_count(input logic [31:0] cnt, input logic ev);
		step_count = ev ? cnt + 32'h00000001 : cnt;
	endfunction : step_count

	// Two-flop reset release
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// Zero wait states; writes land in the access phase
	assign wr_en     = psel_i && penable_i && pwrite_i;
	assign rd_en     = psel_i && !penable_i && !pwrite_i;
	assign pready_o  = 1'b1;
	assign wr_ctl    = wr_en && addr_is(paddr_i, pin_level_drive_off);
	assign wr_dir    = wr_en && addr_is(paddr_i, pin_direction_off);
	assign wr_hertz  = wr_en && addr_is(paddr_i, main_clock_hertz_off);
	assign wr_frames = wr_en && addr_is(paddr_i, frame_count_off);
	assign wr_cycles = wr_en && addr_is(paddr_i, clock_cycle_count_off);
	assign hit       = addr_is(paddr_i, frame_count_off) || addr_is(paddr_i, clock_cycle_count_off) ||
	                   addr_is(paddr_i, main_clock_hertz_off) || addr_is(paddr_i, pin_direction_off) ||
	                   addr_is(paddr_i, pin_level_drive_off);
	assign pslverr_o = psel_i && penable_i && !hit;

	// Pin level and drive register
	always_comb begin
		pin_ctl_nxt = pin_ctl_r;
		if (wr_ctl) begin
			pin_ctl_nxt = pwdata_i & pin_level_drive_mask;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			pin_ctl_r <= pin_level_drive_rst;
		end else begin
			pin_ctl_r <= pin_ctl_nxt;
		end
	end

	// Pin direction register
	always_comb begin
		pin_dir_nxt = pin_dir_r;
		if (wr_dir) begin
			pin_dir_nxt = pwdata_i & pin_direction_mask;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			pin_dir_r <= pin_direction_rst;
		end else begin
			pin_dir_r <= pin_dir_nxt;
		end
	end

	// Main clock frequency register
	always_comb begin
		hertz_nxt = hertz_r;
		if (wr_hertz) begin
			hertz_nxt = pwdata_i;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			hertz_r <= main_clock_hertz_rst;
		end else begin
			hertz_r <= hertz_nxt;
		end
	end

	// Free-running counters, host writes ignored
	always_comb begin
		cycles_nxt = step_count(cycles_r, 1'b1);
		frames_nxt = step_count(frames_r, frame_done_i);
	end

	always_ff @(posedge mclk_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			cycles_r <= 32'h00000000;
			frames_r <= 32'h00000000;
		end else begin
			cycles_r <= cycles_nxt;
			frames_r <= frames_nxt;
		end
	end

	// Read data, loaded in the setup cycle of a read
	always_comb begin
		rdata_nxt = prdata_o;
		if (rd_en) begin
			unique case (paddr_i)
				frame_count_off:       rdata_nxt = frames_r;
				clock_cycle_count_off: rdata_nxt = cycles_r;
				main_clock_hertz_off:  rdata_nxt = hertz_r;
				pin_direction_off:     rdata_nxt = pin_dir_r;
				pin_level_drive_off:   rdata_nxt = pin_ctl_r;
				default:               rdata_nxt = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			prdata_o <= 32'h00000000;
		end else begin
			prdata_o <= rdata_nxt;
		end
	end

	// Pin and pad outputs
	assign display_enable_pin_o      = pin_ctl_r[display_enable_pin_bit];
	assign display_enable_pin_oe_n_o = !pin_dir_r[display_enable_pin_bit];
	assign aux_pin_o                 = pin_ctl_r[3:0];
	assign aux_pin_oe_n_o            = ~pin_dir_r[3:0];
	assign aux_drive_o               = pin_ctl_r[aux_drive_lo +: 2];
	assign video_drive_o             = pin_ctl_r[video_drive_bit];
	assign serial_drive_o            = pin_ctl_r[serial_drive_lo +: 2];
	assign irq_push_pull_o           = pin_ctl_r[irq_type_bit];

	// Counter checks
	chk_cycle_count_step: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		$past(rst_sync_r) |-> cycles_r == $past(cycles_r) + 32'h00000001)
		else $error("cycle counter did not step");
	chk_frame_count_step: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		$past(rst_sync_r) |-> frames_r == $past(frames_r) + {31'h0, $past(frame_done_i)})
		else $error("frame counter wrong");
	chk_frame_idle_hold: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		!frame_done_i |=> $stable(frames_r))
		else $error("frame counter moved without a frame");
	chk_cycle_wrap_zero: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		cycles_r == 32'hFFFFFFFF |=> cycles_r == 32'h00000000)
		else $error("cycle counter did not wrap");
	chk_frame_wrap_zero: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		cycles_r == 32'hFFFFFFFF && frames_r == 32'hFFFFFFFF && frame_done_i |=> frames_r == 32'h00000000)
		else $error("frame counter did not wrap");
	chk_cycles_write_ign: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		wr_cycles |=> cycles_r == $past(cycles_r) + 32'h00000001)
		else $error("cycle counter took a write");
	chk_frames_write_ign: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		wr_frames && !frame_done_i |=> $stable(frames_r))
		else $error("frame counter took a write");

	// Level and drive register checks
	chk_display_enable_pin_level_out: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		wr_en && paddr_i == pin_level_drive_off |=> display_enable_pin_o == $past(pwdata_i[15]))
		else $error("display level not applied");
	chk_aux_drive_code: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		wr_en && paddr_i == pin_level_drive_off |=> aux_drive_o == $past(pwdata_i[14:13]))
		else $error("aux drive code wrong");
	chk_video_drive_bit: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		wr_en && paddr_i == pin_level_drive_off |=> video_drive_o == $past(pwdata_i[12]))
		else $error("video drive wrong");
	chk_serial_drive_code: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		wr_en && paddr_i == pin_level_drive_off |=> serial_drive_o == $past(pwdata_i[11:10]))
		else $error("serial drive wrong");
	chk_irq_pin_type: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		wr_en && paddr_i == pin_level_drive_off |=> irq_push_pull_o == $past(pwdata_i[9]))
		else $error("irq type wrong");
	chk_aux_levels_out: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		wr_en && paddr_i == pin_level_drive_off |=> aux_pin_o == $past(pwdata_i[3:0]))
		else $error("aux levels wrong");
	chk_reserved_zero: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		wr_ctl |=> pin_ctl_r[31:16] == 16'h0000 && pin_ctl_r[8:4] == 5'h00)
		else $error("reserved bits set");
	chk_ctl_hold: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		!wr_ctl |=> $stable(pin_ctl_r))
		else $error("level register changed without a write");
	chk_pads_hold: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		!wr_ctl |=> $stable({aux_drive_o, video_drive_o, serial_drive_o, irq_push_pull_o}))
		else $error("pad settings changed without a write");

	// Direction and frequency checks
	chk_hertz_write: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		wr_en && paddr_i == main_clock_hertz_off |=> hertz_r == $past(pwdata_i))
		else $error("frequency write lost");
	chk_hertz_hold: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		!wr_hertz |=> $stable(hertz_r))
		else $error("frequency changed without a write");
	chk_dir_enable: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		wr_dir |=> aux_pin_oe_n_o == ~$past(pwdata_i[3:0]) && display_enable_pin_oe_n_o == !$past(pwdata_i[15]))
		else $error("direction not applied");
	chk_dir_reserved: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		wr_dir |=> pin_dir_r[31:16] == 16'h0000 && pin_dir_r[14:4] == 11'h000)
		else $error("direction reserved bits set");
	chk_oe_hold: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		!wr_dir |=> $stable({display_enable_pin_oe_n_o, aux_pin_oe_n_o}))
		else $error("output enables changed without a write");

	// Reset value checks
	chk_reset_ctl: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		$rose(rst_sync_r) |-> pin_ctl_r == 32'h00008000 && display_enable_pin_o)
		else $error("level register reset wrong");
	chk_reset_drive: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		$rose(rst_sync_r) |-> aux_drive_o == 2'h0 && !video_drive_o && serial_drive_o == 2'h0)
		else $error("drive codes reset wrong");
	chk_reset_irq_type: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		$rose(rst_sync_r) |-> !irq_push_pull_o)
		else $error("irq type reset wrong");
	chk_reset_hertz: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		$rose(rst_sync_r) |-> hertz_r == 32'h03938700)
		else $error("frequency reset wrong");
	chk_reset_counts: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		$rose(rst_sync_r) |-> cycles_r == 32'h00000000 && frames_r == 32'h00000000)
		else $error("counters reset wrong");
	chk_reset_dir: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		$rose(rst_sync_r) |-> !display_enable_pin_oe_n_o && aux_pin_oe_n_o == 4'hF)
		else $error("direction reset wrong");

	// Bus checks
	chk_pready_high: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		psel_i && penable_i |-> pready_o)
		else $error("slave not ready");
	chk_slverr_unmapped: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		psel_i && penable_i && paddr_i == 12'h000 |-> pslverr_o)
		else $error("unmapped access not flagged");
	chk_slverr_mapped: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		psel_i && penable_i && paddr_i == pin_level_drive_off |-> !pslverr_o)
		else $error("mapped access flagged");
	chk_slverr_idle: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		!psel_i |-> !pslverr_o)
		else $error("error without a transfer");
	chk_read_frames: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		rd_en && paddr_i == frame_count_off |=> prdata_o == $past(frames_r))
		else $error("frame count read wrong");
	chk_read_cycles: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		rd_en && paddr_i == clock_cycle_count_off |=> prdata_o == $past(cycles_r))
		else $error("cycle count read wrong");
	chk_read_hertz: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		rd_en && paddr_i == main_clock_hertz_off |=> prdata_o == $past(hertz_r))
		else $error("frequency read wrong");
	chk_read_dir: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		rd_en && paddr_i == pin_direction_off |=> prdata_o == $past(pin_dir_r))
		else $error("direction read wrong");
	chk_read_ctl: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		rd_en && paddr_i == pin_level_drive_off |=> prdata_o[31:16] == 16'h0000 && prdata_o[8:4] == 5'h00)
		else $error("level register read wrong");
	chk_read_unmapped: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		rd_en && paddr_i == 12'h000 |=> prdata_o == 32'h00000000)
		else $error("unmapped read not zero");
	chk_prdata_hold: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		!rd_en |=> $stable(prdata_o))
		else $error("read data changed without a read");
	chk_read_no_side: assert property (@(posedge mclk_i) disable iff (!rst_sync_r)
		rd_en |=> $stable(pin_ctl_r) && $stable(pin_dir_r) && $stable(hertz_r))
		else $error("read changed a register");

	// Main scenarios
	cov_write_ctl: cover property (@(posedge mclk_i) wr_en && paddr_i == pin_level_drive_off);
	cov_read_cycles: cover property (@(posedge mclk_i) rd_en && paddr_i == clock_cycle_count_off);
	cov_frame_tick: cover property (@(posedge mclk_i) frame_done_i ##1 !frame_done_i ##1 frame_done_i);
	cov_write_dir: cover property (@(posedge mclk_i) wr_dir);
	cov_unmapped: cover property (@(posedge mclk_i) psel_i && penable_i && pslverr_o);
endmodule : misc_gpio_and_counters

// ### tb/host_bfm.sv
`timescale 1ns/10ps
module host_bfm (
	// APB master side
	input  wire logic        mclk_i,
	input  wire logic        pready_i,
	input  wire logic        pslverr_i,
	input  wire logic [31:0] prdata_i,
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic      [11:0] paddr_o,
	output logic      [31:0] pwdata_o
);
	logic hung = 1'b0;
	logic err  = 1'b0;
	initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		@(posedge mclk_i);
		{psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} <= {2'b10, w, a, d};
		@(posedge mclk_i);
		penable_o <= 1'b1;
		do @(posedge mclk_i); while (pready_i !== 1'b1 && ++n < 64);
		hung |= (pready_i !== 1'b1);
		q = prdata_i;
		err = pslverr_i;
		{psel_o, penable_o} <= 2'b00;
	endtask : xfer
endmodule : host_bfm

// ### tb/misc_gpio_and_counters_tb.sv
`timescale 1ns/10ps
module misc_gpio_and_counters_tb;
	logic        clk = 1'b0, rst_n = 1'b0, frame = 1'b0;
	logic        psel, pen, pwr, rdy, dis, dis_oe_n, vid, irq, err;
	logic [11:0] addr;
	logic [31:0] wdata, rdata, q, c0, v;
	logic [3:0]  aux, aux_oe_n;
	logic [1:0]  aux_drv, ser_drv;
	int          mismatches = 0, num_checks = 0;
	wire  [31:0] pins = {16'h0, dis, aux_drv, vid, ser_drv, irq, 5'h0, aux};
	wire  [31:0] oe_n = {27'h0, dis_oe_n, aux_oe_n};
	always #5 clk = ~clk;
	misc_gpio_and_counters u_misc_gpio_and_counters (
		.mclk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr),
		.pwdata_i(wdata), .prdata_o(rdata), .pready_o(rdy), .pslverr_o(err), .frame_done_i(frame),
		.display_enable_pin_i(1'b0), .display_enable_pin_o(dis), .display_enable_pin_oe_n_o(dis_oe_n),
		.aux_pin_i(4'h0), .aux_pin_o(aux), .aux_pin_oe_n_o(aux_oe_n), .aux_drive_o(aux_drv),
		.video_drive_o(vid), .serial_drive_o(ser_drv), .irq_push_pull_o(irq)
	);
	host_bfm u_host_bfm (
		.mclk_i(clk), .pready_i(rdy), .pslverr_i(err), .prdata_i(rdata), .psel_o(psel), .penable_o(pen),
		.pwrite_o(pwr),
		.paddr_o(addr), .pwdata_o(wdata)
	);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		mismatches += int'(got !== exp);
		if (got !== exp) $display("unexpected %0t got %h exp %h", $time, got, exp);
	endtask : chk
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		u_host_bfm.xfer(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rdchk
	task automatic end_of_test();
		mismatches += int'(u_host_bfm.hung);
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk(pins, 32'h8000);
		chk(oe_n, 32'hF);
		rdchk(12'hC, 32'h3938700);
		chk({31'h0, u_host_bfm.err}, 32'h0);
		rdchk(12'h0A0, 32'h0);
		chk({31'h0, u_host_bfm.err}, 32'h1);
		for (int k = 0; k < 4; k++) begin
			v = {16'hFFFF, ~k[0], k[1:0], k[0], k[1:0], k[1], 5'h1F, ~k[1:0], k[1:0]};
			u_host_bfm.xfer(1'b1, 12'h9C, v, q);
			rdchk(12'h9C, v & 32'hFE0F);
			chk(pins, v & 32'hFE0F);
		end
		u_host_bfm.xfer(1'b1, 12'h98, 32'hFFFFFFFF, q);
		u_host_bfm.xfer(1'b1, 12'hC, 32'h2FAF080, q);
		chk(oe_n, 32'h0);
		rdchk(12'hC, 32'h2FAF080);
		$display("register test done");
		u_host_bfm.xfer(1'b0, 12'h8, 32'h0, c0);
		u_host_bfm.xfer(1'b1, 12'h8, 32'h0, q);
		rdchk(12'h8, c0 + 32'h6);
		u_host_bfm.xfer(1'b1, 12'h4, 32'h000000FF, q);
		repeat (10) @(posedge clk) frame <= ~frame;
		rdchk(12'h4, 32'h5);
		$display("counter test done");
		end_of_test();
	end
endmodule : misc_gpio_and_counters_tb
